// *** isrc_readout.sv ***
`timescale 1ns/100ps
`include "isrc_regs.svh"
// Contract
// R1 - frame start issues left sync, loads start row
// R2 - row advance steps counter; match fires right sync
// R3 - normal integration equals lines minus offset plus one
// R4 - mode 1 interval equals lines plus one
// R5 - mode 2 alternates two interval lengths
// R6 - delay register delays valid and end markers
// R7 - delay code adds code minus two, floor zero
// R8 - column and row start registers pick windows
// R9 - array test bits tie columns, pick subsampling
// R10 - unity bit bypasses gain code
// R11 - single output muxes, second path standby
// R12 - standby bit powers down amplifier
// R13 - skew code delays, upper codes invert
// R14 - coarse and fine offset dac codes
// R15 - each converter has own standby bit
// R16 - merge bit multiplexes both converters
// R17 - select bit delays or picks converter
// R18 - ext bit picks pixel or external clock
// R19 - float bit tristates converter outputs
// R20 - gamma bit and invert bit format output
// R21 - upload word is address then data msb-first
// R22 - load strobe writes word, effective at once; here the register takes it on the third sys_clk edge after the strobe
// R23 - one bit shifted per upload clock edge
// R24 - controller pulse widths and suspend
// R25 - strobe only after full word shifted
module isrc_readout
    import isrc_pkg::*;
#(
    parameter int COUNT_WIDTH = 12
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic uploadClk,
    input wire logic uploadData,
    input wire logic loadStrobe,
    input wire logic rowAdvance,
    input wire logic frameStart,
    input wire logic lineDone,
    input wire logic pixelValidRaw,
    input wire logic converterClkExt,
    input wire logic [9:0] conv1Data,
    input wire logic [9:0] conv2Data,
    output logic leftRowSync,
    output logic rightRowSync,
    output logic [11:0] rowStartPtr,
    output logic [11:0] colStartPtr,
    output logic [1:0] columnTie,
    output logic [2:0] subsampleX,
    output logic [2:0] subsampleY,
    output isrc_amp_type ampCtrl,
    output logic [7:0] coarseDac,
    output logic [7:0] fineDac,
    output logic [7:0] darkBusLevel,
    output logic [1:0] convStandby,
    output logic convGamma,
    output logic [2:0] convSkew,
    output logic convClkOut,
    output logic pixelValid,
    output logic lineEnd,
    output logic frameEnd,
    output logic [9:0] convOut,
    output logic [9:0] convOutEn
);
    // upload chain runs on the upload clock, never reset-free
    logic [`ISRC_UPLOAD_BITS-1:0] shiftChain;
    isrc_word_type heldWord;
    logic loadToggle;

    // R21 R23 one bit per edge, address first
    always_ff @(posedge uploadClk or negedge resetn) begin
        if (!resetn) begin
            shiftChain <= 16'h0000;
        end else begin
            shiftChain <= {shiftChain[14:0], uploadData};
        end
    end

    // R22 strobe rise captures word
    always_ff @(posedge loadStrobe or negedge resetn) begin
        if (!resetn) begin
            heldWord <= '0;
            loadToggle <= 1'b0;
        end else begin
            heldWord <= shiftChain;
            loadToggle <= ~loadToggle;
        end
    end

    // toggle crossing; heldWord is stable for three edges after toggle moves
    logic tgl1, tgl2, tgl3;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tgl1 <= 1'b0;
            tgl2 <= 1'b0;
            tgl3 <= 1'b0;
        end else begin
            tgl1 <= loadToggle;
            tgl2 <= tgl1;
            tgl3 <= tgl2;
        end
    end
    wire writeNow = tgl2 ^ tgl3;

    logic [11:0] sequencerReg;
    logic [11:0] nrofLines;
    logic [11:0] integrationRowOffset;
    logic [7:0] markerDelay;
    logic [11:0] windowColStart;
    logic [11:0] windowRowStart;
    logic [7:0] arrayTestSubsample;
    logic [11:0] outputAmpCtrl;
    logic [7:0] coarseOffsetDac;
    logic [7:0] fineOffsetDac;
    logic [7:0] darkBus;
    logic [11:0] converterCtrl;

    // register write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sequencerReg <= 12'h000;
            nrofLines <= `ISRC_RST_NROF_LINES;
            integrationRowOffset <= 12'h000;
            markerDelay <= 8'h00;
            windowColStart <= 12'h000;
            windowRowStart <= 12'h000;
            arrayTestSubsample <= 8'h00;
            outputAmpCtrl <= 12'h000;
            coarseOffsetDac <= 8'h00;
            fineOffsetDac <= `ISRC_RST_FINE_DAC;
            darkBus <= 8'h00;
            converterCtrl <= 12'h000;
        end else if (writeNow) begin
            unique case (heldWord.addr)
                `ISRC_ADDR_SEQUENCER: sequencerReg <= heldWord.data;
                `ISRC_ADDR_NROF_LINES: nrofLines <= heldWord.data;
                `ISRC_ADDR_INT_ROW_OFS: integrationRowOffset <= heldWord.data;
                `ISRC_ADDR_MARKER_DELAY: markerDelay <= heldWord.data[7:0];
                `ISRC_ADDR_COL_START: windowColStart <= heldWord.data;
                `ISRC_ADDR_ROW_START: windowRowStart <= heldWord.data;
                `ISRC_ADDR_ARRAY_TEST: arrayTestSubsample <= heldWord.data[7:0];
                `ISRC_ADDR_AMP_CTRL: outputAmpCtrl <= heldWord.data;
                `ISRC_ADDR_COARSE_DAC: coarseOffsetDac <= heldWord.data[7:0];
                `ISRC_ADDR_FINE_DAC: fineOffsetDac <= heldWord.data[7:0];
                `ISRC_ADDR_DARK_BUS: darkBus <= heldWord.data[7:0];
                `ISRC_ADDR_CONV_CTRL: converterCtrl <= heldWord.data;
                default: ;
            endcase
        end
    end

    // control pulses from the controller pass two flops
    logic [1:0] rowSync, frameSync, lineSync, validSync;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rowSync <= 2'b00;
            frameSync <= 2'b00;
            lineSync <= 2'b00;
            validSync <= 2'b00;
        end else begin
            rowSync <= {rowSync[0], rowAdvance};
            frameSync <= {frameSync[0], frameStart};
            lineSync <= {lineSync[0], lineDone};
            validSync <= {validSync[0], pixelValidRaw};
        end
    end
    logic rowPrev, framePrev;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rowPrev <= 1'b0;
            framePrev <= 1'b0;
        end else begin
            rowPrev <= rowSync[1];
            framePrev <= frameSync[1];
        end
    end
    wire rowEdge = rowSync[1] & ~rowPrev;
    wire frameEdge = frameSync[1] & ~framePrev;
    wire ndrOn = sequencerReg[`ISRC_SEQ_NDR];
    wire ndrMode2 = ndrOn & sequencerReg[`ISRC_SEQ_MODE2];

    // row sequencer: integration offset sets right pointer lag
    isrc_state_type state;
    logic [COUNT_WIDTH-1:0] intCount;
    logic [COUNT_WIDTH-1:0] lineCount;
    logic halfStep;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ISRC_IDLE;
            intCount <= '0;
            lineCount <= '0;
            halfStep <= 1'b0;
            leftRowSync <= 1'b0;
            rightRowSync <= 1'b0;
        end else begin
            leftRowSync <= 1'b0;
            rightRowSync <= 1'b0;
            if (frameEdge) begin
                // R1 left sync load
                leftRowSync <= 1'b1;
                intCount <= '0;
                lineCount <= '0;
                halfStep <= 1'b0;
                state <= ISRC_SCAN;
                // R3 zero offset case
                if (integrationRowOffset == '0) begin
                    rightRowSync <= 1'b1;
                end
            end else begin
                unique case (state)
                    ISRC_IDLE: ;
                    ISRC_SCAN: begin
                        if (rowEdge) begin
                            halfStep <= ~halfStep;
                            // R2 count only alternate pulses in mode 2
                            if (!ndrMode2 || halfStep) begin
                                intCount <= intCount + 1'b1;
                                lineCount <= lineCount + 1'b1;
                                // R2 match fires right sync
                                if (intCount + 1'b1 == integrationRowOffset) begin
                                    rightRowSync <= 1'b1;
                                end
                                // R4 R5 frame length sets read interval
                                if (lineCount + 1'b1 == nrofLines) begin
                                    state <= ISRC_DONE;
                                end
                            end
                        end
                    end
                    ISRC_DONE: ;
                endcase
            end
        end
    end

    // R8 window start positions passed to the address decoders
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rowStartPtr <= 12'h000;
            colStartPtr <= 12'h000;
            columnTie <= 2'b00;
            subsampleX <= 3'h0;
            subsampleY <= 3'h0;
        end else begin
            rowStartPtr <= windowRowStart;
            colStartPtr <= windowColStart;
            // R9 test ties and subsampling
            columnTie <= arrayTestSubsample[1:0];
            subsampleX <= arrayTestSubsample[4:2];
            subsampleY <= arrayTestSubsample[7:5];
        end
    end

    // amplifier and dac settings
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ampCtrl <= '0;
            coarseDac <= 8'h00;
            fineDac <= `ISRC_RST_FINE_DAC;
            darkBusLevel <= 8'h00;
        end else begin
            // R10 unity bypasses gain
            ampCtrl.gain <= outputAmpCtrl[`ISRC_AMP_UNITY] ? 4'h0 :
                outputAmpCtrl[3:0];
            ampCtrl.unity <= outputAmpCtrl[`ISRC_AMP_UNITY];
            // R11 single output mode
            ampCtrl.oneOut <= outputAmpCtrl[`ISRC_AMP_ONE_OUT];
            // R12 full amplifier standby
            ampCtrl.ampStandbyA <= outputAmpCtrl[`ISRC_AMP_STANDBY];
            ampCtrl.ampStandbyB <= outputAmpCtrl[`ISRC_AMP_STANDBY] |
                outputAmpCtrl[`ISRC_AMP_ONE_OUT];
            // R13 upper codes invert
            ampCtrl.skewDelay <= outputAmpCtrl[9:7];
            ampCtrl.skewInvert <= outputAmpCtrl[9];
            // R14 offset dac codes
            coarseDac <= coarseOffsetDac;
            fineDac <= fineOffsetDac;
            darkBusLevel <= darkBus;
        end
    end

    // R6 R7 marker delay lines, code minus two, floor zero
    wire [3:0] vCode = markerDelay[3:0];
    wire [3:0] eCode = markerDelay[7:4];
    wire [3:0] vDly = (vCode > `ISRC_DELAY_OFFSET) ?
        4'(vCode - `ISRC_DELAY_OFFSET) : 4'h0;
    wire [3:0] eDly = (eCode > `ISRC_DELAY_OFFSET) ?
        4'(eCode - `ISRC_DELAY_OFFSET) : 4'h0;
    logic [13:0] validPipe, linePipe, framePipe;
    wire frameEndRaw = lineSync[1] && (state == ISRC_DONE);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            validPipe <= '0;
            linePipe <= '0;
            framePipe <= '0;
            pixelValid <= 1'b0;
            lineEnd <= 1'b0;
            frameEnd <= 1'b0;
        end else begin
            validPipe <= {validPipe[12:0], validSync[1]};
            linePipe <= {linePipe[12:0], lineSync[1]};
            framePipe <= {framePipe[12:0], frameEndRaw};
            pixelValid <= (vDly == 4'h0) ? validSync[1] : validPipe[vDly-1];
            lineEnd <= (eDly == 4'h0) ? lineSync[1] : linePipe[eDly-1];
            frameEnd <= (eDly == 4'h0) ? frameEndRaw : framePipe[eDly-1];
        end
    end

    // converter clock domain: settings cross as slow static levels
    logic [11:0] convCfgA, convCfgB;
    always_ff @(posedge converterClkExt or negedge resetn) begin
        if (!resetn) begin
            convCfgA <= 12'h000;
            convCfgB <= 12'h000;
        end else begin
            convCfgA <= converterCtrl;
            convCfgB <= convCfgA;
        end
    end
    logic [9:0] extMux;
    logic extPhase;
    // R18 external converter clock domain
    always_ff @(posedge converterClkExt or negedge resetn) begin
        if (!resetn) begin
            extPhase <= 1'b0;
            extMux <= 10'h000;
        end else begin
            extPhase <= ~extPhase;
            extMux <= (extPhase ^ convCfgB[`ISRC_CONV_SELECT]) ?
                conv2Data : conv1Data;
        end
    end
    logic [9:0] ext1, ext2;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ext1 <= 10'h000;
            ext2 <= 10'h000;
        end else begin
            ext1 <= extMux;
            ext2 <= ext1;
        end
    end

    // internal pixel clock: half the system clock
    logic pixPhase;
    logic [9:0] intMux, intMuxDly;
    wire mergeDis = converterCtrl[`ISRC_CONV_MERGE_DIS];
    wire selBit = converterCtrl[`ISRC_CONV_SELECT];
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pixPhase <= 1'b0;
            intMux <= 10'h000;
            intMuxDly <= 10'h000;
            convClkOut <= 1'b0;
        end else begin
            pixPhase <= ~pixPhase;
            // R16 merge both converters
            intMux <= pixPhase ? conv2Data : conv1Data;
            intMuxDly <= intMux;
            convClkOut <= converterCtrl[`ISRC_CONV_EXT_CLK] ? 1'b0 : pixPhase;
        end
    end

    logic [9:0] picked;
    always_comb begin
        // R17 select delays or picks
        if (mergeDis) begin
            picked = selBit ? conv2Data : conv1Data;
        end else if (converterCtrl[`ISRC_CONV_EXT_CLK]) begin
            picked = ext2;
        end else begin
            picked = selBit ? intMuxDly : intMux;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            convOut <= 10'h000;
            convOutEn <= 10'h000;
            convStandby <= 2'b00;
            convGamma <= 1'b0;
            convSkew <= 3'h0;
        end else begin
            // R20 invert formatting
            convOut <= converterCtrl[`ISRC_CONV_INVERT] ? ~picked : picked;
            // R19 float all ten lines
            convOutEn <= {10{~converterCtrl[`ISRC_CONV_FLOAT]}};
            // R15 per-converter standby
            convStandby <= converterCtrl[1:0];
            // R20 gamma law select
            convGamma <= converterCtrl[`ISRC_CONV_GAMMA];
            convSkew <= converterCtrl[8:6];
        end
    end
endmodule

// *** isrc_regs.svh ***
`ifndef ISRC_REGS_SVH
`define ISRC_REGS_SVH
// register addresses carried in the upload word
`define ISRC_ADDR_SEQUENCER 4'h0
`define ISRC_ADDR_NROF_PIXELS 4'h1
`define ISRC_ADDR_NROF_LINES 4'h2
`define ISRC_ADDR_INT_ROW_OFS 4'h3
`define ISRC_ADDR_MARKER_DELAY 4'h4
`define ISRC_ADDR_COL_START 4'h5
`define ISRC_ADDR_ROW_START 4'h6
`define ISRC_ADDR_ARRAY_TEST 4'h7
`define ISRC_ADDR_AMP_CTRL 4'h8
`define ISRC_ADDR_COARSE_DAC 4'h9
`define ISRC_ADDR_FINE_DAC 4'ha
`define ISRC_ADDR_DARK_BUS 4'hb
`define ISRC_ADDR_CONV_CTRL 4'hc
// field positions
`define ISRC_SEQ_NDR 0
`define ISRC_SEQ_MODE2 2
`define ISRC_AMP_UNITY 4
`define ISRC_AMP_ONE_OUT 5
`define ISRC_AMP_STANDBY 6
`define ISRC_AMP_SKEW_LSB 7
`define ISRC_CONV_STBY1 0
`define ISRC_CONV_STBY2 1
`define ISRC_CONV_MERGE_DIS 2
`define ISRC_CONV_SELECT 3
`define ISRC_CONV_EXT_CLK 4
`define ISRC_CONV_FLOAT 5
`define ISRC_CONV_GAMMA 9
`define ISRC_CONV_INVERT 10
// reset values
`define ISRC_RST_FINE_DAC 8'h80
`define ISRC_RST_NROF_LINES 12'hbb9
`define ISRC_RST_NROF_PIXELS 12'h451
// marker delay code offset: codes up to 2 add nothing
`define ISRC_DELAY_OFFSET 4'h2
`define ISRC_UPLOAD_BITS 16
`endif

// *** isrc_pkg.sv ***
package isrc_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [11:0] data;
    } isrc_word_type;
    typedef struct packed {
        logic pixelValid;
        logic lineEnd;
        logic frameEnd;
    } isrc_marker_type;
    typedef struct packed {
        logic [3:0] gain;
        logic unity;
        logic oneOut;
        logic ampStandbyA;
        logic ampStandbyB;
        logic [2:0] skewDelay;
        logic skewInvert;
    } isrc_amp_type;
    typedef enum logic [2:0] {
        ISRC_IDLE = 3'b001,
        ISRC_SCAN = 3'b010,
        ISRC_DONE = 3'b100
    } isrc_state_type;
endpackage

// *** isrc_readout_sva.sv ***
`timescale 1ns/100ps
module isrc_readout_sva
    import isrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic frameStart,
    input wire logic pixelValidRaw,
    input wire logic leftRowSync,
    input wire logic rightRowSync,
    input wire logic convClkOut,
    input wire logic pixelValid,
    input wire logic [9:0] convOutEn,
    input isrc_amp_type ampCtrl
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_left_one_cycle: assert property (leftRowSync |=> !leftRowSync)
        else $error("left sync longer than one cycle");
    a_left_after_start: assert property ($rose(frameStart) |-> ##[2:4] leftRowSync)
        else $error("no left sync after frame start");
    a_left_has_cause: assert property ($rose(leftRowSync) |->
        $past(frameStart, 2) || $past(frameStart, 3) || $past(frameStart, 4))
        else $error("left sync without frame start");
    a_clk_half_rate: assert property ($rose(convClkOut) |=> $fell(convClkOut))
        else $error("pixel clock high two cycles");
    a_float_uniform: assert property (convOutEn == 10'h000 || convOutEn == 10'h3ff)
        else $error("output enables disagree");
    // valid delayed by at most thirteen plus pipeline
    a_valid_delay: assert property ($rose(pixelValidRaw) |-> ##[3:16] pixelValid)
        else $error("pixel valid late");
    a_gain_unity: assert property (ampCtrl.unity |-> ampCtrl.gain == 4'h0)
        else $error("gain applied in unity");
    a_one_out_stby: assert property (ampCtrl.oneOut |-> ampCtrl.ampStandbyB)
        else $error("second path active in single output");
    a_full_standby: assert property (ampCtrl.ampStandbyA |-> ampCtrl.ampStandbyB)
        else $error("partial amplifier standby");
    c_left: cover property (leftRowSync);
    c_right: cover property (rightRowSync);
    c_valid: cover property (pixelValid);
    c_unity: cover property (ampCtrl.unity);
endmodule
bind isrc_readout isrc_readout_sva i_sva (.*);

// *** isrc_ctl_model.sv ***
`timescale 1ns/100ps
module isrc_ctl_model (
    input wire logic sys_clk,
    output logic uploadClk,
    output logic uploadData,
    output logic loadStrobe,
    output logic rowAdvance,
    output logic frameStart,
    output logic converterClkExt
);
    initial begin
        uploadClk = 1'b0;
        uploadData = 1'b0;
        loadStrobe = 1'b0;
        rowAdvance = 1'b0;
        frameStart = 1'b0;
        converterClkExt = 1'b0;
    end
    always #25 converterClkExt = ~converterClkExt;
    // address first, msb first, strobe after 16
    task automatic upload(input logic [3:0] a, input logic [11:0] d);
        logic [15:0] w;
        w = {a, d};
        for (int i = 15; i >= 0; i--) begin
            uploadData = w[i];
            #80 uploadClk = 1'b1;
            #80 uploadClk = 1'b0;
        end
        // released line shows the inverse, not a held value
        uploadData = ~w[0];
        // strobe rise with shift clock idle
        #80 loadStrobe = 1'b1;
        #80 loadStrobe = 1'b0;
    endtask
    task automatic row_step();
        @(negedge sys_clk);
        rowAdvance = 1'b1;
        repeat (2) @(negedge sys_clk);
        rowAdvance = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic frame_go();
        @(negedge sys_clk);
        frameStart = 1'b1;
        repeat (3) @(negedge sys_clk);
        frameStart = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
`include "isrc_regs.svh"
module tb;
    import isrc_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic lineDone = 1'b0;
    logic pixelValidRaw = 1'b0;
    logic [9:0] conv1Data = 10'h2b5;
    logic [9:0] conv2Data = 10'h14a;
    logic uploadClk, uploadData, loadStrobe, rowAdvance, frameStart;
    logic converterClkExt, leftRowSync, rightRowSync, convGamma;
    logic convClkOut, pixelValid, lineEnd, frameEnd;
    logic [11:0] rowStartPtr, colStartPtr;
    logic [1:0] columnTie, convStandby;
    logic [2:0] subsampleX, subsampleY, convSkew;
    isrc_amp_type ampCtrl;
    logic [7:0] coarseDac, fineDac, darkBusLevel;
    logic [9:0] convOut, convOutEn;
    int failures = 0;
    int compares = 0;
    int nLeft = 0;
    int nRight = 0;
    always #4 sys_clk = ~sys_clk;
    isrc_readout i_dut (.*);
    isrc_ctl_model i_ctl (.*);
    always @(posedge sys_clk) begin
        if (leftRowSync === 1'b1) nLeft++;
        if (rightRowSync === 1'b1) nRight++;
    end
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // strobes stay well apart so each write settles
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        i_ctl.upload(a, d);
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic t_reset();
        check("fineDac", fineDac, 12'h080);
        check("coarseDac", coarseDac, 12'h000);
        check("rowStartPtr", rowStartPtr, 12'h000);
    endtask
    task automatic t_window();
        wr(`ISRC_ADDR_COL_START, 12'h062);
        wr(`ISRC_ADDR_ROW_START, 12'h089);
        wr(4'he, 12'h5a5);
        check("colStartPtr", colStartPtr, 12'h062);
        check("rowStartPtr", rowStartPtr, 12'h089);
    endtask
    task automatic t_array();
        wr(`ISRC_ADDR_ARRAY_TEST, 12'h0ae);
        check("columnTie", columnTie, 12'h002);
        check("subsampleX", subsampleX, 12'h003);
        check("subsampleY", subsampleY, 12'h005);
    endtask
    task automatic t_amp();
        wr(`ISRC_ADDR_AMP_CTRL, 12'h005);
        check("gain", ampCtrl.gain, 12'h005);
        wr(`ISRC_ADDR_AMP_CTRL, 12'h015);
        check("unity gain", ampCtrl.gain, 12'h000);
        wr(`ISRC_ADDR_AMP_CTRL, 12'h020);
        check("standbyB", ampCtrl.ampStandbyB, 12'h001);
        check("standbyA", ampCtrl.ampStandbyA, 12'h000);
        wr(`ISRC_ADDR_AMP_CTRL, 12'h040);
        check("standbyA", ampCtrl.ampStandbyA, 12'h001);
        for (int c = 0; c < 8; c++) begin
            wr(`ISRC_ADDR_AMP_CTRL, 12'(c << 7));
            check("skewInvert", ampCtrl.skewInvert, 12'(c >> 2));
            check("skewDelay", ampCtrl.skewDelay, 12'(c));
        end
    endtask
    task automatic t_dac();
        wr(`ISRC_ADDR_COARSE_DAC, 12'h0ff);
        wr(`ISRC_ADDR_FINE_DAC, 12'h07f);
        wr(`ISRC_ADDR_DARK_BUS, 12'h03c);
        check("coarseDac", coarseDac, 12'h0ff);
        check("fineDac", fineDac, 12'h07f);
        check("darkBusLevel", darkBusLevel, 12'h03c);
    endtask
    task automatic t_conv();
        logic a;
        wr(`ISRC_ADDR_CONV_CTRL, 12'h003);
        check("convStandby", convStandby, 12'h003);
        check("merged", 12'(convOut === conv1Data || convOut === conv2Data),
              12'h001);
        check("merge phase", convOut, 12'(convClkOut ? conv1Data : conv2Data));
        a = convClkOut;
        @(negedge sys_clk);
        check("pixel clock", convClkOut, 12'({~a}));
        wr(`ISRC_ADDR_CONV_CTRL, 12'h008);
        check("delayed phase", convOut, 12'(convClkOut ? conv2Data : conv1Data));
        wr(`ISRC_ADDR_CONV_CTRL, 12'h00c);
        check("conv2 out", convOut, 12'(conv2Data));
        wr(`ISRC_ADDR_CONV_CTRL, 12'h004);
        check("conv1 out", convOut, 12'(conv1Data));
        check("convOutEn", convOutEn, 12'h3ff);
        wr(`ISRC_ADDR_CONV_CTRL, 12'h404);
        check("inverted", convOut, 12'({~conv1Data}));
        wr(`ISRC_ADDR_CONV_CTRL, 12'h204);
        check("convGamma", convGamma, 12'h001);
        wr(`ISRC_ADDR_CONV_CTRL, 12'h1c4);
        check("convSkew", convSkew, 12'h007);
        wr(`ISRC_ADDR_CONV_CTRL, 12'h024);
        check("floated", convOutEn, 12'h000);
        wr(`ISRC_ADDR_CONV_CTRL, 12'h014);
        check("ext clock", convClkOut, 12'h000);
        @(negedge sys_clk);
        check("ext clock", convClkOut, 12'h000);
        wr(`ISRC_ADDR_CONV_CTRL, 12'h010);
        check("ext merged", 12'(convOut === conv1Data || convOut === conv2Data),
              12'h001);
    endtask
    task automatic meas(input logic sel, output int n);
        n = 0;
        @(negedge sys_clk);
        if (sel) lineDone = 1'b1;
        else pixelValidRaw = 1'b1;
        while ((sel ? lineEnd : pixelValid) !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 40) begin
            failures++;
            wrap_up();
        end
        lineDone = 1'b0;
        pixelValidRaw = 1'b0;
        repeat (20) @(negedge sys_clk);
    endtask
    task automatic t_marker();
        int b0, b1, n, c, e;
        int codes[3] = '{3, 9, 15};
        wr(`ISRC_ADDR_MARKER_DELAY, 12'h000);
        meas(1'b0, b0);
        meas(1'b1, b1);
        // valid and end codes differ so swapped fields show up
        foreach (codes[i]) begin
            c = codes[i];
            e = c ^ 15;
            wr(`ISRC_ADDR_MARKER_DELAY, 12'((e << 4) | c));
            meas(1'b0, n);
            check("valid delay", 12'(n - b0), 12'(c > 2 ? c - 2 : 0));
            meas(1'b1, n);
            check("end delay", 12'(n - b1), 12'(e > 2 ? e - 2 : 0));
        end
    endtask
    task automatic run_frame(input logic [11:0] seq, input int exp);
        int k;
        wr(`ISRC_ADDR_SEQUENCER, seq);
        nLeft = 0;
        nRight = 0;
        i_ctl.frame_go();
        check("left syncs", 12'(nLeft), 12'h001);
        k = 0;
        while (nRight == 0 && k < 12) begin
            i_ctl.row_step();
            k++;
        end
        check("steps to right sync", 12'(k), 12'(exp));
        if (nRight == 0) wrap_up();
    endtask
    task automatic t_seq();
        wr(`ISRC_ADDR_INT_ROW_OFS, 12'h003);
        run_frame(12'h000, 3);
        run_frame(12'h005, 6);
        check("row start kept", rowStartPtr, 12'h089);
        // short frame so the line count runs out
        wr(`ISRC_ADDR_NROF_LINES, 12'h004);
        run_frame(12'h000, 3);
        lineDone = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("frame end early", frameEnd, 12'h000);
        lineDone = 1'b0;
        i_ctl.row_step();
        lineDone = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("frame end", frameEnd, 12'h001);
        lineDone = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_window();
        t_array();
        t_amp();
        t_dac();
        t_conv();
        t_marker();
        t_seq();
        wrap_up();
    end
endmodule
